// >>> count_source.sv
// Purpose: External clock source for the count pin
// Assumes: Pin idles low between bursts
// Notes: Each level lasts at least two clocks
`timescale 1ns/1ns
module count_source (
    // Clock
    input wire logic i_sys_clk,
    // Count pin
    output logic o_pin
);
    initial o_pin = 1'b0;
    // Shorter levels could slip past the synchroniser
    task automatic burst(input int n, input int half);
        repeat (n) begin
            repeat (half) @(posedge i_sys_clk);
            o_pin <= 1'b1;
            repeat (half) @(posedge i_sys_clk);
            o_pin <= 1'b0;
        end
    endtask
    task automatic level(input logic v);
        @(posedge i_sys_clk);
        o_pin <= v;
    endtask
endmodule

// >>> tb_top.sv
// Purpose: Self-checking bench for timer_zero
// Assumes: Tasks are entered just after a rising edge
// Notes: Timer counts allow for the unknown tick phase
`timescale 1ns/1ns
module tb_top;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, slp = 1'b0, rdy, err, irq, pin;
    logic [7:0] pa = 8'h00, r, hb, lo;
    logic [31:0] pwd = 32'h0, prd, rd;
    int fails = 0, n_tests = 0, cyc = 0, t_take, t0, n, lf = 93763;
    always #10 clk = ~clk;
    timer_zero i_dut (.i_sys_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err),
        .i_count_pin(pin), .i_sleep(slp), .o_overflow_irq(irq));
    count_source i_src (.i_sys_clk(clk), .o_pin(pin));
    function automatic int nxt(int s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Lowest legal count: two ticks inhibited, one more for phase
    function automatic logic [15:0] tmr_exp(logic [15:0] base, int k);
        return base + 16'(k / 4) - 16'h3;
    endfunction
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        t_take = cyc;
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (rdy !== 1'b1 && k < 20);
        if (rdy !== 1'b1) fails++;
        rd = prd;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got, input int tol);
        n_tests++;
        if ((16'(got - exp) <= tol) !== 1'b1) begin
            fails++;
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("fails %0d n_tests %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, 8'h0c, 32'h0);
        chk("ctrl", 16'h00ff, rd[15:0], 0);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped", 16'h0, rd[15:0], 0);
        lf = nxt(lf);
        r = 8'hf0 | 8'(lf[3:0]);
        n = 1 + lf[6:4];
        apb(1'b1, 8'h00, 32'(r));
        i_src.burst(n, 2 + lf[9:8]);
        repeat (6) @(posedge clk);
        apb(1'b0, 8'h00, 32'h0);
        chk("ext", 8'(r + n), rd[15:0], 0);
        apb(1'b0, 8'h04, 32'h0);
        chk("buf8", 16'h0, rd[15:0], 0);
        apb(1'b0, 8'h08, 32'h0);
        chk("flag8", {13'h0, r + n > 255, 2'h0}, rd[15:0], 0);
        apb(1'b1, 8'h0c, 32'hf8);
        i_src.level(1'b1);
        repeat (6) @(posedge clk);
        apb(1'b0, 8'h00, 32'h0);
        chk("no_rise", 8'(r + n), rd[15:0], 0);
        i_src.level(1'b0);
        repeat (6) @(posedge clk);
        apb(1'b0, 8'h00, 32'h0);
        chk("fall", 8'(r + n + 1), rd[15:0], 0);
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, 8'h0c, 32'(8'he0 + c));
            apb(1'b1, 8'h00, 32'h0);
            i_src.burst((4 << c) - 1, 2);
            repeat (6) @(posedge clk);
            apb(1'b0, 8'h00, 32'h0);
            chk("pre", 16'h1, rd[15:0], 0);
            apb(1'b0, 8'h0c, 32'h0);
            chk("keep", 16'(8'he0 + c), rd[15:0], 0);
        end
        for (int i = 0; i < 2; i++) begin
            lf = nxt(lf);
            hb = i ? 8'hff : 8'(lf[6:0]);
            apb(1'b1, 8'h08, 32'h0);
            apb(1'b1, 8'h0c, 32'h88);
            apb(1'b1, 8'h04, 32'(hb));
            apb(1'b1, 8'h00, 32'hf8);
            t0 = t_take;
            repeat (20) @(posedge clk);
            apb(1'b0, 8'h00, 32'h0);
            lo = rd[7:0];
            n = t_take - t0;
            repeat (40) @(posedge clk);
            apb(1'b0, 8'h04, 32'h0);
            chk("cnt16", tmr_exp({hb, 8'hf8}, n), {rd[7:0], lo}, 2);
            apb(1'b0, 8'h08, 32'h0);
            chk("flag16", {13'h0, i[0], 2'h0}, rd[15:0], 0);
        end
        apb(1'b1, 8'h08, 32'h24);
        repeat (3) @(posedge clk);
        chk("irq_on", 16'h1, 16'(irq), 0);
        apb(1'b1, 8'h08, 32'h04);
        repeat (3) @(posedge clk);
        chk("irq_mask", 16'h0, 16'(irq), 0);
        apb(1'b1, 8'h08, 32'h20);
        repeat (3) @(posedge clk);
        chk("irq_clr", 16'h0, 16'(irq), 0);
        slp <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        lo = rd[7:0];
        repeat (40) @(posedge clk);
        apb(1'b0, 8'h00, 32'h0);
        chk("sleep", 16'(lo), rd[15:0], 0);
        end_sim();
    end
endmodule

// >>> timer_zero.sv
// Purpose: 8/16-bit timer/counter with 8-bit prescaler behind an APB slave
// Assumes: i_count_pin may be asynchronous to i_sys_clk; i_sys_clk is the phase clock
// Notes: Registers: low byte, high buffer, interrupt control, timer control, sleep
`timescale 1ns/1ns
module timer_zero (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Link and system
    input wire logic i_count_pin,
    input wire logic i_sleep,
    // Interrupt request
    output logic o_overflow_irq
);
    logic [7:0] timer_control_q;
    logic [7:0] count_high_buffer_q;
    logic [15:0] counter_q;
    logic overflow_flag_q;
    logic overflow_int_enable_q;
    logic [7:0] int_ctrl_other_q;
    logic soft_sleep_q;
    logic [7:0] prescale_q;
    logic [1:0] phase_q;
    logic [1:0] inhibit_q;
    logic pin_meta_q;
    logic pin_sync_q;
    logic pin_prev_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;

    logic setup;
    logic wr_en;
    logic rd_en;
    logic wr_low;
    logic rd_low;
    logic instr_tick;
    logic ext_edge;
    logic src_tick;
    logic pre_tick;
    logic count_tick;
    logic halted;
    logic eight_bit;
    logic wrap;
    logic [2:0] ratio;
    logic [15:0] counter_d;
    logic addr_ok;
    logic low_carry;

    // Register selects, decoded once from the address
    logic sel_low;
    logic sel_high;
    logic sel_int;
    logic sel_ctrl;
    logic sel_sleep;

    // Write strobes, one per register
    logic wr_high;
    logic wr_int;
    logic wr_ctrl;
    logic wr_sleep;

    // Prescaler compare and edge detection
    logic [7:0] pre_mask;
    logic pre_full;
    logic pre_run;
    logic pin_rise;
    logic pin_fall;

    // Side effects of low byte accesses
    logic inhibit_load;
    logic latch_high;

    // Read path
    logic [7:0] int_ctrl_word;
    logic [31:0] read_word;

    // Address decode; anything else answers with an error
    assign sel_low = i_paddr == timer_zero_pkg::ADDR_COUNT_LOW;
    assign sel_high = i_paddr == timer_zero_pkg::ADDR_COUNT_HIGH;
    assign sel_int = i_paddr == timer_zero_pkg::ADDR_INT_CTRL;
    assign sel_ctrl = i_paddr == timer_zero_pkg::ADDR_TIMER_CTRL;
    assign sel_sleep = i_paddr == timer_zero_pkg::ADDR_SLEEP_CTRL;
    assign addr_ok = sel_low || sel_high || sel_int || sel_ctrl || sel_sleep;

    assign setup = i_psel && !i_penable;
    assign wr_en = setup && i_pwrite && addr_ok;
    assign rd_en = setup && !i_pwrite && addr_ok;
    assign wr_low = wr_en && sel_low;
    assign rd_low = rd_en && sel_low;
    assign wr_high = wr_en && sel_high;
    assign wr_int = wr_en && sel_int;
    assign wr_ctrl = wr_en && sel_ctrl;
    assign wr_sleep = wr_en && sel_sleep;

    assign eight_bit = timer_control_q[timer_zero_pkg::TC_EIGHT_BIT];
    assign ratio = timer_control_q[timer_zero_pkg::TC_RATIO_HI -: 3];
    assign halted = i_sleep || soft_sleep_q || !timer_control_q[timer_zero_pkg::TC_TIMER_ON];

    // One-cycle pulse per instruction cycle
    assign instr_tick = phase_q == 2'(timer_zero_pkg::INSTR_CLKS - 1);

    // Edge selection works on the synchronised pin only
    assign pin_rise = !pin_prev_q && pin_sync_q;
    assign pin_fall = pin_prev_q && !pin_sync_q;
    assign ext_edge = timer_control_q[timer_zero_pkg::TC_EDGE_SEL] ? pin_fall : pin_rise;
    assign src_tick = timer_control_q[timer_zero_pkg::TC_CLK_SRC] ? ext_edge : instr_tick;

    // Mask of the low ratio+1 prescaler bits; all ones there means the next source tick carries out
    for (genvar b = 0; b < 8; b++) begin : g_pre_mask
        assign pre_mask[b] = 3'(b) <= ratio;
    end

    assign pre_full = (prescale_q & pre_mask) == pre_mask;
    assign pre_tick = src_tick && pre_full;
    assign pre_run = src_tick && !halted && !timer_control_q[timer_zero_pkg::TC_PRE_BYPASS];
    assign count_tick = !halted && inhibit_q == 2'd0 && !wr_low
        && (timer_control_q[timer_zero_pkg::TC_PRE_BYPASS] ? src_tick : pre_tick);
    assign wrap = count_tick && (eight_bit ? counter_q[7:0] == 8'hff : counter_q == 16'hffff);

    // Only timer mode loses ticks after a write; an external edge is lost only in the write cycle itself
    assign inhibit_load = wr_low && !timer_control_q[timer_zero_pkg::TC_CLK_SRC];
    // In 8-bit mode the buffer keeps what software last wrote
    assign latch_high = rd_low && !eight_bit;

    // Low byte always counts; the high byte only takes its carry in 16-bit mode
    always_comb begin
        counter_d = counter_q;
        low_carry = 1'b0;
        if (count_tick) begin
            {low_carry, counter_d[7:0]} = {1'b0, counter_q[7:0]} + 9'h001;
            if (!eight_bit && low_carry) begin
                counter_d[15:8] = counter_q[15:8] + 8'h01;
            end
        end
    end

    // Pin synchroniser: only the second stage is looked at
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
        end else begin
            pin_meta_q <= i_count_pin;
            pin_sync_q <= pin_meta_q;
        end
    end

    // Edge history resets to the idle low level so no false edge follows reset
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            pin_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= pin_sync_q;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            phase_q <= 2'd0;
        end else begin
            phase_q <= phase_q + 2'd1;
        end
    end

    // Prescaler: invisible to software, cleared by any counter write
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            prescale_q <= 8'h00;
        end else if (wr_low) begin
            prescale_q <= 8'h00;
        end else if (pre_run) begin
            prescale_q <= prescale_q + 8'h01;
        end
    end

    // Write inhibit counted in instruction cycles
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            inhibit_q <= 2'd0;
        end else if (inhibit_load) begin
            inhibit_q <= 2'(timer_zero_pkg::WRITE_INHIBIT_CYCLES);
        end else if (instr_tick && inhibit_q != 2'd0) begin
            inhibit_q <= inhibit_q - 2'd1;
        end
    end

    // Counter: the true high byte is loaded only from the buffer
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            counter_q <= timer_zero_pkg::COUNT_RST;
        end else if (wr_low) begin
            counter_q <= {count_high_buffer_q, i_pwdata[7:0]};
        end else begin
            counter_q <= counter_d;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            count_high_buffer_q <= timer_zero_pkg::COUNT_HIGH_RST;
        end else if (wr_high) begin
            count_high_buffer_q <= i_pwdata[7:0];
        end else if (latch_high) begin
            count_high_buffer_q <= counter_q[15:8];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            timer_control_q <= timer_zero_pkg::TIMER_CTRL_RST;
        end else if (wr_ctrl) begin
            timer_control_q <= i_pwdata[7:0];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            soft_sleep_q <= 1'b0;
        end else if (wr_sleep) begin
            soft_sleep_q <= i_pwdata[0];
        end
    end

    // Plain storage for the interrupt control bits this block does not own
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            int_ctrl_other_q <= timer_zero_pkg::INT_CTRL_RST;
        end else if (wr_int) begin
            int_ctrl_other_q <= i_pwdata[7:0];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            overflow_int_enable_q <= timer_zero_pkg::INT_CTRL_RST[timer_zero_pkg::IC_OVF_IE];
        end else if (wr_int) begin
            overflow_int_enable_q <= i_pwdata[timer_zero_pkg::IC_OVF_IE];
        end
    end

    // Overflow flag: the wrap wins over a clearing write in the same cycle
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            overflow_flag_q <= timer_zero_pkg::INT_CTRL_RST[timer_zero_pkg::IC_OVF_FLAG];
        end else if (wrap) begin
            overflow_flag_q <= 1'b1;
        end else if (wr_int) begin
            overflow_flag_q <= i_pwdata[timer_zero_pkg::IC_OVF_FLAG];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= overflow_flag_q && overflow_int_enable_q;
        end
    end

    assign int_ctrl_word = {int_ctrl_other_q[7:6], overflow_int_enable_q, int_ctrl_other_q[4:3], overflow_flag_q,
        int_ctrl_other_q[1:0]};

    // Read mux; the counter's true high byte is never on it
    always_comb begin
        read_word = 32'h0000_0000;
        case (i_paddr)
            timer_zero_pkg::ADDR_COUNT_LOW: begin
                read_word = {24'h000000, counter_q[7:0]};
            end
            timer_zero_pkg::ADDR_COUNT_HIGH: begin
                read_word = {24'h000000, count_high_buffer_q};
            end
            timer_zero_pkg::ADDR_INT_CTRL: begin
                read_word = {24'h000000, int_ctrl_word};
            end
            timer_zero_pkg::ADDR_TIMER_CTRL: begin
                read_word = {24'h000000, timer_control_q};
            end
            timer_zero_pkg::ADDR_SLEEP_CTRL: begin
                read_word = {31'h00000000, soft_sleep_q};
            end
            default: begin
                read_word = 32'h0000_0000;
            end
        endcase
    end

    // APB: answer in the first access cycle, no wait states
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= setup;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= setup && !addr_ok;
        end
    end

    // Read data is zero outside a read answer so stale values never linger on the bus
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata_q <= read_word;
        end else begin
            prdata_q <= 32'h0000_0000;
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_overflow_irq = irq_q;
endmodule

// >>> timer_zero_checker.sv
// Purpose: Port-level assertions for timer_zero
// Assumes: Setup is answered in the next cycle
// Notes: Bound to the design at the foot of this file
`timescale 1ns/1ns
module timer_zero_checker (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // APB and interrupt
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_overflow_irq
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    logic setup, bad, tc_wr_q;
    assign setup = i_psel && !i_penable;
    assign bad = !(i_paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10});
    // Control reads can be judged on their own only until the first control write after reset
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            tc_wr_q <= 1'b0;
        end else if (setup && i_pwrite && i_paddr == 8'h0c) begin
            tc_wr_q <= 1'b1;
        end
    end
    ready_after_setup_a: assert property (setup |=> o_pready) else $error("pready missing");
    ready_cause_a: assert property (o_pready |-> $past(setup)) else $error("pready without setup");
    ready_pulse_a: assert property (o_pready |=> !o_pready) else $error("pready too long");
    err_with_ready_a: assert property (o_pslverr |-> o_pready) else $error("pslverr alone");
    err_unmapped_a: assert property (setup && bad |=> o_pslverr && o_prdata == 32'h0) else $error("bad addr");
    err_mapped_a: assert property (setup && !bad |=> !o_pslverr) else $error("pslverr on mapped");
    ctrl_reset_a: assert property (setup && !i_pwrite && i_paddr == 8'h0c && !tc_wr_q
        |=> o_prdata == 32'h000000ff) else $error("control reset value");
    irq_masked_a: assert property (setup && i_pwrite && i_paddr == 8'h08 && !i_pwdata[5]
        |-> ##2 !o_overflow_irq) else $error("irq not masked");
endmodule
bind timer_zero timer_zero_checker i_chk (.i_sys_clk, .i_reset, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_overflow_irq);

// >>> timer_zero_pkg.sv
// Purpose: Shared constants for the prescaled 8/16-bit timer/counter
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Offsets are byte addresses
package timer_zero_pkg;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h00;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h04;
    localparam logic [7:0] ADDR_INT_CTRL = 8'h08;
    localparam logic [7:0] ADDR_TIMER_CTRL = 8'h0c;
    localparam logic [7:0] ADDR_SLEEP_CTRL = 8'h10;
    // timer_control fields
    localparam int TC_TIMER_ON = 7;
    localparam int TC_EIGHT_BIT = 6;
    localparam int TC_CLK_SRC = 5;
    localparam int TC_EDGE_SEL = 4;
    localparam int TC_PRE_BYPASS = 3;
    localparam int TC_RATIO_HI = 2;
    // interrupt_control fields
    localparam int IC_OVF_IE = 5;
    localparam int IC_OVF_FLAG = 2;
    // Reset values
    localparam logic [7:0] TIMER_CTRL_RST = 8'hff;
    localparam logic [7:0] COUNT_HIGH_RST = 8'h00;
    localparam logic [7:0] INT_CTRL_RST = 8'h00;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    // Instruction cycle is four oscillator cycles
    localparam int INSTR_CLKS = 4;
    localparam int WRITE_INHIBIT_CYCLES = 2;
endpackage
